// *** common/pulse_sign_pkg.sv ***
// Constants and carrier types for the pulse output, phase calibration and power sign register bank.
// Assumes a 16-bit register port and signed per-phase powers produced on the same clock.
package pulse_sign_pkg;

  // Register addresses.
  localparam logic [15:0] PULSE_OUTPUT_CONFIG_ADDR = 16'hE610;
  localparam logic [15:0] PHASE_A_CALIBRATION_ADDR = 16'hE614;
  localparam logic [15:0] PHASE_B_CALIBRATION_ADDR = 16'hE615;
  localparam logic [15:0] PHASE_C_CALIBRATION_ADDR = 16'hE616;
  localparam logic [15:0] POWER_SIGN_FLAGS_ADDR = 16'hE617;

  localparam int NUM_OUTPUTS = 3;
  localparam int NUM_PHASES = 3;
  localparam int POWER_W = 24;
  localparam int SUM_W = POWER_W + 2;

  // Pulse output configuration field layout.
  localparam int SELECT_W = 3;
  localparam int SELECT_LSB = 0;
  localparam int DISABLE_LSB = 9;
  localparam int CAPTURE_LSB = 12;
  localparam logic [15:0] PULSE_OUTPUT_CONFIG_RESET = 16'h0E88;
  localparam logic [15:0] PULSE_OUTPUT_CONFIG_MASK = 16'h7FFF;

  // Quantity select codes; anything above the last one is reserved.
  localparam logic [2:0] SEL_TOTAL_ACTIVE = 3'h0;
  localparam logic [2:0] SEL_TOTAL_REACTIVE = 3'h1;
  localparam logic [2:0] SEL_APPARENT = 3'h2;
  localparam logic [2:0] SEL_FUND_ACTIVE = 3'h3;
  localparam logic [2:0] SEL_FUND_REACTIVE = 3'h4;

  // Phase calibration layout and compensation ranges.
  localparam int COMP_W = 10;
  localparam int AMOUNT_W = 9;
  localparam logic [15:0] PHASE_CALIBRATION_RESET = 16'h0000;
  localparam logic [15:0] PHASE_CALIBRATION_MASK = 16'h03FF;
  localparam logic [9:0] COMP_CURRENT_FOLD = 10'h180;
  localparam logic [9:0] COMP_VOLTAGE_BASE = 10'h200;
  localparam logic [9:0] COMP_VOLTAGE_FOLD = 10'h380;

  // Power sign flag layout.
  localparam int ACTIVE_SIGN_LSB = 0;
  localparam int REACTIVE_SIGN_LSB = 4;
  localparam int SUM_ONE_SIGN_BIT = 3;
  localparam int SUM_TWO_SIGN_BIT = 7;
  localparam int SUM_THREE_SIGN_BIT = 8;
  localparam logic [15:0] POWER_SIGN_FLAGS_RESET = 16'h0000;

  typedef struct packed {
    logic signed [POWER_W-1:0] totalActive;
    logic signed [POWER_W-1:0] fundActive;
    logic signed [POWER_W-1:0] totalReactive;
    logic signed [POWER_W-1:0] fundReactive;
    logic signed [POWER_W-1:0] apparent;
  } phase_power_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wrData;
    logic write;
    logic read;
  } reg_request_t;

  typedef struct packed {
    logic voltageChannel;
    logic [AMOUNT_W-1:0] amount;
  } phase_comp_t;

endpackage : pulse_sign_pkg

// *** src/pulse_output_phase_sign_regs.sv ***
// Pulse output configuration, phase calibration and power sign flag registers.
// Assumes the power datapath, the pulse converters and the measurement and computation mode
// registers live elsewhere on core_clk and feed this block directly.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

module pulse_output_phase_sign_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire pulse_sign_pkg::reg_request_t regRequest,
  output logic [15:0] regRdData,
  input wire pulse_sign_pkg::phase_power_t [pulse_sign_pkg::NUM_PHASES-1:0] phasePower,
  input wire logic activeSignSourceSelect,
  input wire logic reactiveSignSourceSelect,
  input wire logic [pulse_sign_pkg::NUM_OUTPUTS-1:0][pulse_sign_pkg::NUM_PHASES-1:0] outputPhaseTerms,
  input wire logic [pulse_sign_pkg::NUM_OUTPUTS-1:0] converterPulse,
  output logic [pulse_sign_pkg::NUM_OUTPUTS-1:0][pulse_sign_pkg::SELECT_W-1:0] quantitySelect,
  output logic [pulse_sign_pkg::NUM_OUTPUTS-1:0] converterEnable,
  output logic [pulse_sign_pkg::NUM_OUTPUTS-1:0] pulseOutput,
  output logic [pulse_sign_pkg::NUM_OUTPUTS-1:0] energyCapture,
  output pulse_sign_pkg::phase_comp_t [pulse_sign_pkg::NUM_PHASES-1:0] phaseComp
);
  import pulse_sign_pkg::*;

  typedef struct packed {
    logic [15:0] pulseOutputConfig;
    logic [NUM_PHASES-1:0][15:0] phaseCalibration;
    logic [15:0] powerSignFlags;
    logic [15:0] rdData;
    logic [NUM_OUTPUTS-1:0][SELECT_W-1:0] quantity;
    logic [NUM_OUTPUTS-1:0] convEnable;
    logic [NUM_OUTPUTS-1:0] pulse;
    logic [NUM_OUTPUTS-1:0] capture;
    phase_comp_t [NUM_PHASES-1:0] comp;
  } state_t;

  state_t state;
  state_t next_state;

  // Sum of the chosen quantity over the chosen phases; reserved codes contribute nothing.
  function automatic logic signed [SUM_W-1:0] pathSum(
    input logic [SELECT_W-1:0] sel,
    input logic [NUM_PHASES-1:0] terms,
    input phase_power_t [NUM_PHASES-1:0] pw
  );
    logic signed [SUM_W-1:0] acc;
    logic signed [POWER_W-1:0] term;
    acc = '0;
    for (int p = 0; p < NUM_PHASES; p++) begin
      unique case (sel)
        SEL_TOTAL_ACTIVE: term = pw[p].totalActive;
        SEL_TOTAL_REACTIVE: term = pw[p].totalReactive;
        SEL_APPARENT: term = pw[p].apparent;
        SEL_FUND_ACTIVE: term = pw[p].fundActive;
        SEL_FUND_REACTIVE: term = pw[p].fundReactive;
        default: term = '0;
      endcase
      if (terms[p]) begin
        acc = SUM_W'(acc + SUM_W'(term));
      end
    end
    return acc;
  endfunction : pathSum

  // Fold the 10-bit calibration field onto a channel and an amount.
  function automatic phase_comp_t foldComp(input logic [COMP_W-1:0] val);
    phase_comp_t res;
    res.voltageChannel = val[COMP_W-1];
    if (val >= COMP_VOLTAGE_FOLD) begin
      res.amount = AMOUNT_W'(val - COMP_VOLTAGE_FOLD);
    end else if (val >= COMP_VOLTAGE_BASE) begin
      res.amount = AMOUNT_W'(val - COMP_VOLTAGE_BASE);
    end else if (val >= COMP_CURRENT_FOLD) begin
      res.amount = AMOUNT_W'(val - COMP_CURRENT_FOLD);
    end else begin
      res.amount = AMOUNT_W'(val);
    end
    return res;
  endfunction : foldComp

  // Next-state logic: register writes, read data, pulse gating, sign tracking and folding.
  // Outputs are registered, so every derived signal lags its cause by one clock.
  always_comb begin
    logic [SELECT_W-1:0] sel;
    logic selValid;
    logic [15:0] flags;
    logic signed [SUM_W-1:0] sum;
    sel = '0;
    selValid = 1'b0;
    sum = '0;
    next_state = state;
    flags = '0; // Bits 15..9 stay zero.

    // Writes; the sign flag register and unmapped addresses ignore them.
    if (regRequest.write) begin
      unique case (regRequest.addr)
        PULSE_OUTPUT_CONFIG_ADDR: begin
          next_state.pulseOutputConfig = regRequest.wrData & PULSE_OUTPUT_CONFIG_MASK;
        end
        PHASE_A_CALIBRATION_ADDR, PHASE_B_CALIBRATION_ADDR, PHASE_C_CALIBRATION_ADDR: begin
          next_state.phaseCalibration[2'(regRequest.addr - PHASE_A_CALIBRATION_ADDR)] =
            regRequest.wrData & PHASE_CALIBRATION_MASK;
        end
        default: begin
        end
      endcase
    end

    // Reads return in the next cycle only; unmapped addresses read zero.
    next_state.rdData = '0;
    if (regRequest.read) begin
      unique case (regRequest.addr)
        PULSE_OUTPUT_CONFIG_ADDR: next_state.rdData = state.pulseOutputConfig;
        PHASE_A_CALIBRATION_ADDR: next_state.rdData = state.phaseCalibration[0];
        PHASE_B_CALIBRATION_ADDR: next_state.rdData = state.phaseCalibration[1];
        PHASE_C_CALIBRATION_ADDR: next_state.rdData = state.phaseCalibration[2];
        POWER_SIGN_FLAGS_ADDR: next_state.rdData = state.powerSignFlags;
        default: next_state.rdData = '0;
      endcase
    end

    // Per output: quantity choice, pin gating and energy capture strobes.
    for (int k = 0; k < NUM_OUTPUTS; k++) begin
      sel = state.pulseOutputConfig[SELECT_LSB + k*SELECT_W +: SELECT_W];
      selValid = (sel <= SEL_FUND_REACTIVE);
      next_state.quantity[k] = sel;
      next_state.convEnable[k] = selValid;
      // The converter keeps running while the pin is disabled.
      next_state.pulse[k] = converterPulse[k] & selValid & ~state.pulseOutputConfig[DISABLE_LSB + k];
      // Capture follows converter pulses, so a disabled pin still latches.
      next_state.capture[k] = converterPulse[k] & selValid & state.pulseOutputConfig[CAPTURE_LSB + k];
    end

    // Per phase sign flags, taken from total or fundamental power.
    for (int p = 0; p < NUM_PHASES; p++) begin
      flags[ACTIVE_SIGN_LSB + p] = activeSignSourceSelect ?
        phasePower[p].fundActive[POWER_W-1] : phasePower[p].totalActive[POWER_W-1];
      flags[REACTIVE_SIGN_LSB + p] = reactiveSignSourceSelect ?
        phasePower[p].fundReactive[POWER_W-1] : phasePower[p].totalReactive[POWER_W-1];
      next_state.comp[p] = foldComp(state.phaseCalibration[p][COMP_W-1:0]);
    end

    // Sign of each pulse datapath sum.
    sum = pathSum(state.pulseOutputConfig[SELECT_LSB +: SELECT_W], outputPhaseTerms[0], phasePower);
    flags[SUM_ONE_SIGN_BIT] = sum[SUM_W-1];
    sum = pathSum(state.pulseOutputConfig[SELECT_LSB + SELECT_W +: SELECT_W], outputPhaseTerms[1], phasePower);
    flags[SUM_TWO_SIGN_BIT] = sum[SUM_W-1];
    sum = pathSum(state.pulseOutputConfig[SELECT_LSB + 2*SELECT_W +: SELECT_W], outputPhaseTerms[2], phasePower);
    flags[SUM_THREE_SIGN_BIT] = sum[SUM_W-1];
    next_state.powerSignFlags = flags;
  end

  // State register; reset values put all pins disabled and output three on apparent power.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.pulseOutputConfig <= PULSE_OUTPUT_CONFIG_RESET;
      state.phaseCalibration <= {NUM_PHASES{PHASE_CALIBRATION_RESET}};
      state.powerSignFlags <= POWER_SIGN_FLAGS_RESET;
      state.rdData <= '0;
      state.quantity <= '0;
      state.convEnable <= '0;
      state.pulse <= '0;
      state.capture <= '0;
      state.comp <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Every output is a field of the state register.
  assign regRdData = state.rdData;
  assign quantitySelect = state.quantity;
  assign converterEnable = state.convEnable;
  assign pulseOutput = state.pulse;
  assign energyCapture = state.capture;
  assign phaseComp = state.comp;

endmodule : pulse_output_phase_sign_regs

// *** verification/pulse_output_phase_sign_regs_assertions.sv ***
// Port-level checks for the pulse output, calibration and sign flag registers.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pulse_output_phase_sign_regs_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire pulse_sign_pkg::reg_request_t regRequest,
  input wire logic [15:0] regRdData,
  input wire logic [2:0] converterPulse,
  input wire logic [2:0][2:0] quantitySelect,
  input wire logic [2:0] converterEnable,
  input wire logic [2:0] pulseOutput,
  input wire logic [2:0] energyCapture,
  input wire pulse_sign_pkg::phase_comp_t [2:0] phaseComp
);
  import pulse_sign_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Pin pulses on output one and capture pulses on output two only ever follow a converter pulse one cycle earlier.
  property p_pin_src; pulseOutput[0] |-> $past(converterPulse[0]); endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin pulse without source");
  property p_cap_src; energyCapture[1] |-> $past(converterPulse[1]); endproperty
  a_cap_src: assert property (p_cap_src) else $error("capture without source");
  // Both cycles are checked so a select change in flight cannot fire it.
  property p_resv; $past(quantitySelect[2]) > 3'h4 && quantitySelect[2] > 3'h4 |-> !(pulseOutput[2] || energyCapture[2]);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code pulsed");
  property p_conv_en; $past(reset_n) && $stable(quantitySelect[2]) |-> converterEnable[2] == (quantitySelect[2] <= 3'h4);
  endproperty
  a_conv_en: assert property (p_conv_en) else $error("converter enable wrong");
  property p_flag_resv; regRequest.read && regRequest.addr == POWER_SIGN_FLAGS_ADDR |=> regRdData[15:9] == 7'h00;
  endproperty
  a_flag_resv: assert property (p_flag_resv) else $error("flag reserved bits set");
  property p_cal_resv; regRequest.read && regRequest.addr inside {[16'hE614:16'hE616]} |=> regRdData[15:10] == 6'h00;
  endproperty
  a_cal_resv: assert property (p_cal_resv) else $error("calibration reserved bits set");
  property p_cfg15; regRequest.read && regRequest.addr == PULSE_OUTPUT_CONFIG_ADDR |=> !regRdData[15]; endproperty
  a_cfg15: assert property (p_cfg15) else $error("config bit 15 set");
  property p_side; regRequest.write && regRequest.addr == 16'hE614 ##1 !(regRequest.write && regRequest.addr == 16'hE614)
    |=> phaseComp[0].voltageChannel == $past(regRequest.wrData[9], 2); endproperty
  a_side: assert property (p_side) else $error("compensation channel wrong");
endmodule : pulse_output_phase_sign_regs_checker

bind pulse_output_phase_sign_regs pulse_output_phase_sign_regs_checker checker_i (.core_clk, .reset_n, .regRequest,
  .regRdData, .converterPulse, .quantitySelect, .converterEnable, .pulseOutput, .energyCapture, .phaseComp);

// *** verification/test_pulse_output_phase_sign_regs.sv ***
// Self-checking bench for the pulse output, calibration and sign flag registers.
// Assumes the bound checker; all inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
module test_pulse_output_phase_sign_regs;
  import pulse_sign_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_request_t regRequest = '0;
  phase_power_t [2:0] phasePower = '0;
  logic activeSignSourceSelect = 1'b0;
  logic reactiveSignSourceSelect = 1'b0;
  logic [2:0][2:0] outputPhaseTerms = '0;
  logic [2:0] converterPulse = '0;
  logic [15:0] regRdData;
  logic [2:0][2:0] quantitySelect;
  logic [2:0] converterEnable;
  logic [2:0] pulseOutput;
  logic [2:0] energyCapture;
  phase_comp_t [2:0] phaseComp;
  int errCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int folds[7] = '{383, 384, 511, 512, 895, 896, 1023};

  pulse_output_phase_sign_regs DUT (.core_clk, .reset_n, .regRequest, .regRdData, .phasePower, .activeSignSourceSelect,
    .reactiveSignSourceSelect, .outputPhaseTerms, .converterPulse, .quantitySelect, .converterEnable, .pulseOutput,
    .energyCapture, .phaseComp);

  // Clock at 100 MHz.
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // A stuck run would never report, so a cycle ceiling ends it as a failure.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errCount++;
      stopTest();
    end
  end

  task automatic stopTest();
    $display("mismatches %0d comparisons %0d", errCount, samplesChecked);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stopTest

  task automatic check(input string name, input logic [15:0] expected, input logic [15:0] seen);
    samplesChecked++;
    if (seen !== expected) begin
      $display("unexpected %s expected %h seen %h", name, expected, seen);
      errCount++;
    end
  endtask : check

  // Single-cycle strobes; read data is taken in the one cycle after the read.
  task automatic regWrite(input logic [15:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    regRequest <= '{addr, data, 1'b1, 1'b0};
    @(posedge core_clk);
    regRequest.write <= 1'b0;
  endtask : regWrite

  task automatic readCheck(input string name, input logic [15:0] addr, input logic [15:0] expected);
    @(posedge core_clk);
    regRequest <= '{addr, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    regRequest.read <= 1'b0;
    #1 check(name, expected, regRdData);
  endtask : readCheck

  task automatic resetValues();
    readCheck("config", PULSE_OUTPUT_CONFIG_ADDR, 16'h0E88);
    check("select three", 16'h0002, 16'(quantitySelect[2]));
    for (int i = 0; i < 3; i++) begin
      readCheck("calibration", PHASE_A_CALIBRATION_ADDR + 16'(i), 16'h0000);
    end
    readCheck("flags", POWER_SIGN_FLAGS_ADDR, 16'h0000);
  endtask : resetValues

  // Ranges above 383 fold back by 384 within each channel half.
  task automatic calibration();
    logic [9:0] v;
    regWrite(PHASE_A_CALIBRATION_ADDR, 16'hFFFF);
    readCheck("cal a", PHASE_A_CALIBRATION_ADDR, 16'h03FF);
    regWrite(PHASE_B_CALIBRATION_ADDR, 16'h0123);
    regWrite(PHASE_C_CALIBRATION_ADDR, 16'h0200);
    readCheck("cal b", PHASE_B_CALIBRATION_ADDR, 16'h0123);
    readCheck("cal c", PHASE_C_CALIBRATION_ADDR, 16'h0200);
    check("comp b", 16'h0123, 16'(phaseComp[1]));
    check("comp c", 16'h0200, 16'(phaseComp[2]));
    foreach (folds[i]) begin
      v = 10'(folds[i]);
      regWrite(PHASE_A_CALIBRATION_ADDR, {6'h00, v});
      @(posedge core_clk);
      #1 check("comp a", 16'({v[9], v[8:0] - (v[8:7] == 2'b11 ? 9'h180 : 9'h000)}), 16'(phaseComp[0]));
    end
  endtask : calibration

  task automatic pulseCase(input logic [15:0] cfg, input logic [2:0] pin, input logic [2:0] cap);
    regWrite(PULSE_OUTPUT_CONFIG_ADDR, cfg);
    @(posedge core_clk);
    converterPulse <= 3'b111;
    @(posedge core_clk);
    converterPulse <= 3'b000;
    #1 check("pin", 16'(pin), 16'(pulseOutput));
    check("capture", 16'(cap), 16'(energyCapture));
  endtask : pulseCase

  task automatic pulses();
    for (int c = 0; c < 8; c++) begin
      pulseCase(16'h7008 | 16'(c << 6), {c <= 4, 2'b11}, {c <= 4, 2'b11});
      check("enable", 16'({c <= 4, 2'b11}), 16'(converterEnable));
      check("select three", 16'(c), 16'(quantitySelect[2]));
      check("select one two", 16'h0008, 16'({quantitySelect[1], quantitySelect[0]}));
    end
    pulseCase(16'h0E88, 3'b000, 3'b000);
    pulseCase(16'h7E88, 3'b000, 3'b111);
    pulseCase(16'h8088, 3'b111, 3'b000);
    readCheck("config", PULSE_OUTPUT_CONFIG_ADDR, 16'h0088);
  endtask : pulses

  task automatic signs();
    @(posedge core_clk);
    outputPhaseTerms <= {3'b010, 3'b100, 3'b001};
    phasePower[0].totalActive <= -24'sd5;
    phasePower[1].fundActive <= -24'sd5;
    phasePower[1].fundReactive <= -24'sd3;
    phasePower[2].totalReactive <= -24'sd7;
    regWrite(PULSE_OUTPUT_CONFIG_ADDR, 16'h0108);
    regWrite(POWER_SIGN_FLAGS_ADDR, 16'hFFFF);
    regWrite(16'h1234, 16'hFFFF);
    readCheck("flags", POWER_SIGN_FLAGS_ADDR, 16'h01C9);
    readCheck("unmapped", 16'h1234, 16'h0000);
    @(posedge core_clk);
    activeSignSourceSelect <= 1'b1;
    reactiveSignSourceSelect <= 1'b1;
    regWrite(PULSE_OUTPUT_CONFIG_ADDR, 16'h0148);
    readCheck("flags", POWER_SIGN_FLAGS_ADDR, 16'h00AA);
  endtask : signs

  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    resetValues();
    calibration();
    pulses();
    signs();
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    readCheck("config after reset", PULSE_OUTPUT_CONFIG_ADDR, 16'h0E88);
    stopTest();
  end
endmodule : test_pulse_output_phase_sign_regs
